/* hdl/pwacu_map.svh */
// Constants of the word arithmetic and compare unit: opcodes, limits, flag reset values.
// Assumes the execution engine supplies operands and stores results on the same clock.
// Function
// [RQ1] The relational box compares two 16-bit words for equal, not equal, less and less-or-equal.
// [RQ2] The box output conducts like a normally-open contact, on only while the comparison is true.
// [RQ3] Assignment copies the source to the destination, bit to bit or word to word only.
// [RQ4] Binary add stores the low 16 bits of the unsigned sum and sets carry only above HFFFF.
// [RQ5] Binary subtract stores first minus second and sets carry when the first is smaller.
// [RQ6] BCD add stores the packed decimal sum and puts the decimal carry in the carry flag.
// [RQ7] BCD add with an invalid digit sets data fault, writes nothing and holds carry.
// [RQ8] BCD subtract keeps borrow in carry, and an invalid digit sets data fault and holds carry.
// [RQ9] Binary multiply always writes the full double-word product to the destination and next word.
// [RQ10] BCD multiply past the area end sets data fault and stores only the low product word.
// [RQ11] Binary divide writes the quotient to the destination and the remainder to the remainder word.
// [RQ12] A zero binary divisor sets data fault and writes neither quotient nor remainder.
// [RQ13] BCD divide with zero divisor or invalid digit sets data fault and writes nothing.
// [RQ14] OR combines both operands bit by bit into the destination, all bits or all words.
// [RQ15] AND combines both operands bit by bit into the destination, all bits or all words.
// [RQ16] Carry and data fault hold their values until an instruction that affects them.
`ifndef PWACU_MAP_SVH
`define PWACU_MAP_SVH

`define PWACU_WORD_W      16
`define PWACU_OP_W        4
`define PWACU_CARRY_RST   1'h0
`define PWACU_FAULT_RST   1'h0
`define PWACU_BCD_MOD     15'h2710
`define PWACU_BCD_DIGIT_MAX 4'h9
`define PWACU_BIN_MAX     17'h0FFFF

`define PWACU_OP_ASSIGN   4'h0
`define PWACU_OP_ADD      4'h1
`define PWACU_OP_SUB      4'h2
`define PWACU_OP_BADD     4'h3
`define PWACU_OP_BSUB     4'h4
`define PWACU_OP_MUL      4'h5
`define PWACU_OP_BMUL     4'h6
`define PWACU_OP_DIV      4'h7
`define PWACU_OP_BDIV     4'h8
`define PWACU_OP_OR       4'h9
`define PWACU_OP_AND      4'hA
`define PWACU_OP_EQ       4'hB
`define PWACU_OP_NE       4'hC
`define PWACU_OP_LT       4'hD
`define PWACU_OP_LE       4'hE

`endif

/* hdl/pwacu_pkg.sv */
// Types of the word arithmetic and compare unit.
// Assumes pwacu_map.svh is on the include path.
`include "pwacu_map.svh"
package pwacu_pkg;
  typedef enum logic [`PWACU_OP_W-1:0] {
    PWACU_ASSIGN = `PWACU_OP_ASSIGN,
    PWACU_ADD    = `PWACU_OP_ADD,
    PWACU_SUB    = `PWACU_OP_SUB,
    PWACU_BADD   = `PWACU_OP_BADD,
    PWACU_BSUB   = `PWACU_OP_BSUB,
    PWACU_MUL    = `PWACU_OP_MUL,
    PWACU_BMUL   = `PWACU_OP_BMUL,
    PWACU_DIV    = `PWACU_OP_DIV,
    PWACU_BDIV   = `PWACU_OP_BDIV,
    PWACU_OR     = `PWACU_OP_OR,
    PWACU_AND    = `PWACU_OP_AND,
    PWACU_EQ     = `PWACU_OP_EQ,
    PWACU_NE     = `PWACU_OP_NE,
    PWACU_LT     = `PWACU_OP_LT,
    PWACU_LE     = `PWACU_OP_LE
  } pwacu_op_e;
  typedef logic [`PWACU_WORD_W-1:0] pwacu_word_t;
endpackage : pwacu_pkg

/* hdl/pwacu_top.sv */
// Word arithmetic, logic and relational datapath of the controller's instruction processor.
// Assumes the execution engine on the same clock presents one instruction per req pulse
// and stores the registered results that appear one cycle later with done.
`timescale 1ns/10ps
`include "pwacu_map.svh"
module pwacu_top (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 req,
  input  wire pwacu_pkg::pwacu_op_e op,
  input  wire logic                 bit_mode,
  input  wire pwacu_pkg::pwacu_word_t src1,
  input  wire pwacu_pkg::pwacu_word_t src2,
  input  wire logic                 rung_power,
  input  wire logic                 dest_at_area_end,
  output logic                      done,
  output logic                      dest_we,
  output pwacu_pkg::pwacu_word_t    dest_data,
  output logic                      dest_hi_we,
  output pwacu_pkg::pwacu_word_t    dest_hi_data,
  output logic                      rem_we,
  output pwacu_pkg::pwacu_word_t    rem_data,
  output logic                      bit_we,
  output logic                      bit_data,
  output logic                      box_on,
  output logic                      carry_flag,
  output logic                      data_fault_flag
);

  // Every nibble must be a decimal digit
  function automatic logic bcd_ok(input logic [15:0] w);
    bcd_ok = (w[15:12] <= `PWACU_BCD_DIGIT_MAX) && (w[11:8] <= `PWACU_BCD_DIGIT_MAX) &&
             (w[7:4] <= `PWACU_BCD_DIGIT_MAX) && (w[3:0] <= `PWACU_BCD_DIGIT_MAX);
  endfunction : bcd_ok

  function automatic logic [13:0] bcd2bin(input logic [15:0] w);
    logic [13:0] acc;
    acc = 14'(w[15:12]) * 14'h03E8;
    acc = acc + 14'(w[11:8]) * 14'h0064;
    acc = acc + 14'(w[7:4]) * 14'h000A;
    bcd2bin = acc + 14'(w[3:0]);
  endfunction : bcd2bin

  // Shift-add-3 conversion; one shared loop serves every BCD result width
  function automatic logic [31:0] bin2bcd(input logic [26:0] v);
    logic [31:0] bcd;
    bcd = 32'h0000_0000;
    for (int i = 26; i >= 0; i--) begin
      for (int d = 0; d < 8; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[30:0], v[i]};
    end
    bin2bcd = bcd;
  endfunction : bin2bcd

  logic [13:0] a_dec;
  logic [13:0] b_dec;
  logic        bcd_valid;
  logic [16:0] bin_sum;
  logic [16:0] bin_diff;
  logic [31:0] bin_prod;
  logic [14:0] dec_sum;
  logic [14:0] dec_diff;
  logic [26:0] dec_prod;
  logic [31:0] dec_prod_bcd;

  assign a_dec        = bcd2bin(src1);
  assign b_dec        = bcd2bin(src2);
  assign bcd_valid    = bcd_ok(src1) && bcd_ok(src2);
  assign bin_sum      = {1'h0, src1} + {1'h0, src2};
  assign bin_diff     = {1'h0, src1} - {1'h0, src2};
  assign bin_prod     = {16'h0000, src1} * {16'h0000, src2};
  assign dec_sum      = {1'h0, a_dec} + {1'h0, b_dec};
  assign dec_diff     = {1'h0, a_dec} - {1'h0, b_dec};
  assign dec_prod     = {13'h0000, a_dec} * {13'h0000, b_dec};
  assign dec_prod_bcd = bin2bcd(dec_prod);

  logic        dest_we_next;
  logic [15:0] dest_data_next;
  logic        dest_hi_we_next;
  logic [15:0] dest_hi_data_next;
  logic        rem_we_next;
  logic [15:0] rem_data_next;
  logic        bit_we_next;
  logic        bit_data_next;
  logic        box_next;
  logic        carry_next;
  logic        fault_next;
  logic [14:0] dec_adj;
  logic [31:0] dec_tmp;

  always_comb begin
    dec_adj           = 15'h0000;
    dec_tmp           = 32'h0000_0000;
    dest_we_next      = 1'b0;
    dest_data_next    = 16'h0000;
    dest_hi_we_next   = 1'b0;
    dest_hi_data_next = 16'h0000;
    rem_we_next       = 1'b0;
    rem_data_next     = 16'h0000;
    bit_we_next       = 1'b0;
    bit_data_next     = 1'b0;
    box_next          = box_on;
    carry_next        = carry_flag;
    fault_next        = data_fault_flag;
    case (op)
      pwacu_pkg::PWACU_ASSIGN: begin
        if (bit_mode) begin
          bit_we_next   = 1'b1; // RQ3
          bit_data_next = src1[0];
        end else begin
          dest_we_next   = 1'b1; // RQ3
          dest_data_next = src1;
        end
      end
      pwacu_pkg::PWACU_ADD: begin
        dest_we_next   = 1'b1;
        dest_data_next = bin_sum[15:0]; // RQ4
        carry_next     = bin_sum > `PWACU_BIN_MAX; // RQ4
      end
      pwacu_pkg::PWACU_SUB: begin
        dest_we_next   = 1'b1;
        dest_data_next = bin_diff[15:0]; // RQ5
        carry_next     = src1 < src2; // RQ5
      end
      pwacu_pkg::PWACU_BADD: begin
        // Invalid digits leave carry alone and write nothing
        fault_next = !bcd_valid; // RQ7
        if (bcd_valid) begin
          carry_next     = dec_sum >= `PWACU_BCD_MOD; // RQ6
          dec_adj        = carry_next ? dec_sum - `PWACU_BCD_MOD : dec_sum;
          dec_tmp        = bin2bcd({12'h000, dec_adj});
          dest_we_next   = 1'b1; // RQ6
          dest_data_next = dec_tmp[15:0];
        end
      end
      pwacu_pkg::PWACU_BSUB: begin
        fault_next = !bcd_valid; // RQ8
        if (bcd_valid) begin
          carry_next     = a_dec < b_dec; // RQ8
          // Ten's complement wrap on borrow
          dec_adj        = carry_next ? dec_diff + `PWACU_BCD_MOD : dec_diff;
          dec_tmp        = bin2bcd({12'h000, dec_adj});
          dest_we_next   = 1'b1;
          dest_data_next = dec_tmp[15:0];
        end
      end
      pwacu_pkg::PWACU_MUL: begin
        dest_we_next      = 1'b1; // RQ9
        dest_hi_we_next   = 1'b1; // RQ9
        dest_data_next    = bin_prod[15:0];
        dest_hi_data_next = bin_prod[31:16];
      end
      pwacu_pkg::PWACU_BMUL: begin
        // Invalid digits raise the fault as an overrun does, but store nothing, not even the low word
        fault_next        = dest_at_area_end || !bcd_valid; // RQ10
        dest_we_next      = bcd_valid; // RQ10
        dest_hi_we_next   = bcd_valid && !dest_at_area_end; // RQ10
        dest_data_next    = dec_prod_bcd[15:0];
        dest_hi_data_next = dec_prod_bcd[31:16];
      end
      pwacu_pkg::PWACU_DIV: begin
        fault_next = src2 == 16'h0000; // RQ12
        if (src2 != 16'h0000) begin
          dest_we_next   = 1'b1; // RQ11
          rem_we_next    = 1'b1; // RQ11
          dest_data_next = src1 / src2;
          rem_data_next  = src1 % src2;
        end
      end
      pwacu_pkg::PWACU_BDIV: begin
        fault_next = !bcd_valid || b_dec == 14'h0000; // RQ13
        if (bcd_valid && b_dec != 14'h0000) begin
          dec_tmp        = bin2bcd({13'h0000, a_dec / b_dec});
          dest_data_next = dec_tmp[15:0];
          dec_tmp        = bin2bcd({13'h0000, a_dec % b_dec});
          rem_data_next  = dec_tmp[15:0];
          dest_we_next   = 1'b1; // RQ13
          rem_we_next    = 1'b1; // RQ13
        end
      end
      pwacu_pkg::PWACU_OR: begin
        if (bit_mode) begin
          bit_we_next   = 1'b1;
          bit_data_next = src1[0] | src2[0]; // RQ14
        end else begin
          dest_we_next   = 1'b1;
          dest_data_next = src1 | src2; // RQ14
        end
      end
      pwacu_pkg::PWACU_AND: begin
        if (bit_mode) begin
          bit_we_next   = 1'b1;
          bit_data_next = src1[0] & src2[0]; // RQ15
        end else begin
          dest_we_next   = 1'b1;
          dest_data_next = src1 & src2; // RQ15
        end
      end
      pwacu_pkg::PWACU_EQ: box_next = rung_power && (src1 == src2); // RQ1 RQ2
      pwacu_pkg::PWACU_NE: box_next = rung_power && (src1 != src2); // RQ1 RQ2
      pwacu_pkg::PWACU_LT: box_next = rung_power && (src1 < src2); // RQ1 RQ2
      pwacu_pkg::PWACU_LE: box_next = rung_power && (src1 <= src2); // RQ1 RQ2
      default: begin
        // Unknown opcode: acknowledged, nothing written, flags held
        box_next = box_on;
      end
    endcase
  end

  // Write strobes and results
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done         <= 1'b0;
      dest_we      <= 1'b0;
      dest_hi_we   <= 1'b0;
      rem_we       <= 1'b0;
      bit_we       <= 1'b0;
      dest_data    <= 16'h0000;
      dest_hi_data <= 16'h0000;
      rem_data     <= 16'h0000;
      bit_data     <= 1'b0;
    end else if (ce) begin
      done       <= req;
      dest_we    <= req && dest_we_next;
      dest_hi_we <= req && dest_hi_we_next;
      rem_we     <= req && rem_we_next;
      bit_we     <= req && bit_we_next;
      if (req) begin
        dest_data    <= dest_data_next;
        dest_hi_data <= dest_hi_data_next;
        rem_data     <= rem_data_next;
        bit_data     <= bit_data_next;
      end
    end
  end

  // Relational contact output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      box_on <= 1'b0;
    end else if (ce && req) begin
      box_on <= box_next; // RQ2
    end
  end

  // Special flags hold between instructions that touch them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag      <= `PWACU_CARRY_RST;
      data_fault_flag <= `PWACU_FAULT_RST;
    end else if (ce && req) begin
      carry_flag      <= carry_next; // RQ16
      data_fault_flag <= fault_next; // RQ16
    end
  end

endmodule : pwacu_top

/* testbench/pwacu_top_sva.sv */
// Port assertions for the word arithmetic and compare unit.
// Assumes one clock and results one cycle after a taken request.
`timescale 1ns/10ps
module pwacu_top_sva (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  input wire logic                   req,
  input wire pwacu_pkg::pwacu_op_e   op,
  input wire pwacu_pkg::pwacu_word_t src1,
  input wire pwacu_pkg::pwacu_word_t src2,
  input wire logic                   rung_power,
  input wire logic                   done,
  input wire logic                   dest_we,
  input wire pwacu_pkg::pwacu_word_t dest_data,
  input wire logic                   dest_hi_we,
  input wire pwacu_pkg::pwacu_word_t dest_hi_data,
  input wire logic                   rem_we,
  input wire pwacu_pkg::pwacu_word_t rem_data,
  input wire logic                   box_on,
  input wire logic                   carry_flag,
  input wire logic                   data_fault_flag
);
  logic go;
  assign go = ce && req;
  function automatic logic bcd_ok(input logic [15:0] w);
    return w[3:0] < 4'hA && w[7:4] < 4'hA && w[11:8] < 4'hA && w[15:12] < 4'hA;
  endfunction : bcd_ok
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_done_pulse: assert property (go |=> done) else $error("no done");
  a_add_carry: assert property (go && op == pwacu_pkg::PWACU_ADD |=> dest_we
    && {carry_flag, dest_data} == {1'b0, $past(src1)} + $past(src2)) else $error("add");
  a_sub_borrow: assert property (go && op == pwacu_pkg::PWACU_SUB |=> dest_we
    && carry_flag == ($past(src1) < $past(src2)) && dest_data == $past(src1) - $past(src2))
    else $error("sub");
  a_mul_words: assert property (go && op == pwacu_pkg::PWACU_MUL |=> dest_we && dest_hi_we
    && {dest_hi_data, dest_data} == $past(src1) * $past(src2)) else $error("mul");
  a_div_zero: assert property (go && op == pwacu_pkg::PWACU_DIV && src2 == 16'h0000
    |=> data_fault_flag && !dest_we && !rem_we) else $error("div zero");
  a_div_split: assert property (go && op == pwacu_pkg::PWACU_DIV && src2 != 16'h0000
    |=> !data_fault_flag && rem_we && dest_data == $past(src1) / $past(src2)
    && rem_data == $past(src1) % $past(src2)) else $error("div");
  a_box_less: assert property (go && op == pwacu_pkg::PWACU_LT
    |=> box_on == ($past(src1) < $past(src2) && $past(rung_power))) else $error("lt");
  a_box_equal: assert property (go && op == pwacu_pkg::PWACU_EQ
    |=> box_on == ($past(src1) == $past(src2) && $past(rung_power))) else $error("eq");
  a_flag_hold: assert property (go && (op == pwacu_pkg::PWACU_OR || op == pwacu_pkg::PWACU_AND)
    |=> $stable(carry_flag) && $stable(data_fault_flag)) else $error("flags moved");
  a_bcd_bad: assert property (go && op == pwacu_pkg::PWACU_BADD && !(bcd_ok(src1)
    && bcd_ok(src2)) |=> data_fault_flag && !dest_we && $stable(carry_flag)) else $error("bcd");
  a_idle_quiet: assert property (ce && !req
    |=> !done && !dest_we && !dest_hi_we && !rem_we) else $error("stray pulse");
  a_freeze_hold: assert property (!ce |=> $stable(done) && $stable(dest_data)
    && $stable(box_on) && $stable(carry_flag) && $stable(data_fault_flag))
    else $error("state moved while frozen");
endmodule : pwacu_top_sva
bind pwacu_top pwacu_top_sva u_sva (.clk, .rst_n, .ce, .req, .op, .src1, .src2, .rung_power,
  .done, .dest_we, .dest_data, .dest_hi_we, .dest_hi_data, .rem_we, .rem_data, .box_on,
  .carry_flag, .data_fault_flag);

/* testbench/pwacu_top_tb.sv */
// Self-checking bench: directed corner cases then random instructions against a model.
// Assumes a one-cycle answer per taken request, as the unit's contract gives.
`timescale 1ns/10ps
`include "pwacu_map.svh"
module pwacu_top_tb;
  logic clk, rst_n, ce, req, bit_mode, rung_power, dest_at_area_end;
  logic done, dest_we, dest_hi_we, rem_we, bit_we, bit_data, box_on, carry_flag, data_fault_flag;
  pwacu_pkg::pwacu_op_e   op;
  pwacu_pkg::pwacu_word_t src1, src2, dest_data, dest_hi_data, rem_data;
  int          miscompares, compares;
  logic [31:0] seed, r;
  logic        cy_m, flt_m, box_m;
  pwacu_top dut (.clk, .rst_n, .ce, .req, .op, .bit_mode, .src1, .src2, .rung_power,
    .dest_at_area_end, .done, .dest_we, .dest_data, .dest_hi_we, .dest_hi_data, .rem_we,
    .rem_data, .bit_we, .bit_data, .box_on, .carry_flag, .data_fault_flag);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int b2i(input logic [15:0] w);
    return w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
  endfunction : b2i
  function automatic logic [15:0] i2b(input int v);
    return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : i2b
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: word %h, model %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_flag(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, model %b", $time, g, e);
    end
  endtask : chk_flag
  task automatic run(input pwacu_pkg::pwacu_op_e o, input logic [15:0] a, input logic [15:0] b,
                     input logic bm, input logic rp, input logic ae);
    int          x, y;
    logic        bad, wd, wh, wr, wb;
    logic [15:0] ed, eh, er;
    @(posedge clk);
    op <= o;
    src1 <= a;
    src2 <= b;
    bit_mode <= bm;
    rung_power <= rp;
    dest_at_area_end <= ae;
    req <= 1'b1;
    x = b2i(a);
    y = b2i(b);
    bad = a != i2b(x) || b != i2b(y);
    wd = o < pwacu_pkg::PWACU_EQ;
    wh = 1'b0;
    wr = 1'b0;
    case (o)
      pwacu_pkg::PWACU_ASSIGN: ed = a;
      pwacu_pkg::PWACU_OR: ed = a | b;
      pwacu_pkg::PWACU_AND: ed = a & b;
      pwacu_pkg::PWACU_ADD: {cy_m, ed} = {1'b0, a} + b;
      pwacu_pkg::PWACU_SUB: {cy_m, ed} = {a < b, a - b};
      pwacu_pkg::PWACU_MUL: {wh, eh, ed} = {1'b1, 32'(a) * 32'(b)};
      pwacu_pkg::PWACU_DIV: {flt_m, wd, wr, ed, er} = {b == 0, b != 0, b != 0, a / b, a % b};
      pwacu_pkg::PWACU_BADD: {flt_m, wd, ed} = {bad, !bad, i2b(x + y)};
      pwacu_pkg::PWACU_BSUB: {flt_m, wd, ed} = {bad, !bad, i2b(x - y + 10000)};
      pwacu_pkg::PWACU_BMUL: {flt_m, wd, wh, ed, eh} =
        {bad || ae, !bad, !(bad || ae), i2b(x * y), i2b(x * y / 10000)};
      pwacu_pkg::PWACU_BDIV: {flt_m, wd, wr} = {bad || y == 0, !(bad || y == 0), !(bad || y == 0)};
      pwacu_pkg::PWACU_EQ: box_m = rp && a == b;
      pwacu_pkg::PWACU_NE: box_m = rp && a != b;
      pwacu_pkg::PWACU_LT: box_m = rp && a < b;
      pwacu_pkg::PWACU_LE: box_m = rp && a <= b;
      // Unused opcode: acknowledged only, box and flags held
      default: wd = 1'b0;
    endcase
    if (wr && o == pwacu_pkg::PWACU_BDIV) {ed, er} = {i2b(x / y), i2b(x % y)};
    if (!bad && o == pwacu_pkg::PWACU_BADD) cy_m = x + y > 9999;
    if (!bad && o == pwacu_pkg::PWACU_BSUB) cy_m = x < y;
    wb = bm && o <= pwacu_pkg::PWACU_ASSIGN || bm && o inside {pwacu_pkg::PWACU_OR,
      pwacu_pkg::PWACU_AND};
    wd = wd && !wb;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk_flag(done, 1'b1);
    chk_flag(dest_we, wd);
    chk_flag(dest_hi_we, wh);
    chk_flag(rem_we, wr);
    chk_flag(bit_we, wb);
    chk_flag(carry_flag, cy_m);
    chk_flag(data_fault_flag, flt_m);
    chk_flag(box_on, box_m);
    if (wd) chk_word(dest_data, ed);
    if (wh) chk_word(dest_hi_data, eh);
    if (wr) chk_word(rem_data, er);
    if (wb) chk_flag(bit_data, ed[0]);
  endtask : run
  task automatic conclude();
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, ce, req, bit_mode, rung_power, dest_at_area_end} = 6'b010000;
    op = pwacu_pkg::PWACU_ASSIGN;
    {src1, src2} = '0;
    {miscompares, compares, cy_m, flt_m, box_m} = '0;
    seed = 32'h5DBE;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    run(pwacu_pkg::PWACU_ADD, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
    // A request offered while frozen must leave done, dest_we and carry untouched
    @(posedge clk);
    ce <= 1'b0;
    req <= 1'b1;
    op <= pwacu_pkg::PWACU_SUB;
    src1 <= 16'h0002;
    src2 <= 16'h0001;
    @(posedge clk);
    ce <= 1'b1;
    req <= 1'b0;
    #1;
    chk_flag(done, 1'b0);
    chk_flag(dest_we, 1'b0);
    chk_flag(carry_flag, cy_m);
    run(pwacu_pkg::PWACU_SUB, 16'h0001, 16'h0002, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_DIV, 16'h1234, 16'h0000, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_BADD, 16'h9999, 16'h0001, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_BADD, 16'h12A4, 16'h0001, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_BSUB, 16'h0001, 16'h0002, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_BMUL, 16'h9999, 16'h9999, 1'b0, 1'b0, 1'b1);
    run(pwacu_pkg::PWACU_BDIV, 16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
    run(pwacu_pkg::PWACU_EQ, 16'h5A5A, 16'h5A5A, 1'b0, 1'b1, 1'b0);
    run(pwacu_pkg::PWACU_OR, 16'h0F00, 16'h00F1, 1'b1, 1'b0, 1'b0);
    // Mid-run reset with carry, fault and box all set
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    {cy_m, flt_m, box_m} = {`PWACU_CARRY_RST, `PWACU_FAULT_RST, 1'b0};
    chk_flag(carry_flag, cy_m);
    chk_flag(data_fault_flag, flt_m);
    chk_flag(box_on, box_m);
    repeat (600) begin
      r = rnd();
      run(pwacu_pkg::pwacu_op_e'(r[3:0]), r[8] ? i2b(r[31:16] % 10000) : r[31:16],
          r[9] ? i2b(r[26:12] % 10000) : 16'(rnd() >> 16), r[5], r[6], r[7]);
    end
    conclude();
  end
endmodule : pwacu_top_tb
